// file: logic/dct_trim_bank.sv
/*
  Calibration trim bank for the fast excitation converter: unlock key,
  gain trim, three offset trims and the converter configuration, all on
  an AXI4-Lite slave. Drives the gain and the selected offset trim to the
  converter's code correction path.
  Assumes one clock, a synchronous active-high reset and a fast_mode_pin
  level from outside the clock domain (high = high speed mode).
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module dct_trim_bank #(
  parameter int ADDR_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,

  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,

  input  wire logic              fast_mode_pin,
  output logic [11:0]            gain_trim,
  output logic [11:0]            offset_trim,
  output logic                   output_attenuator_on,
  output logic                   excitation_gain_select,
  output logic                   fast_mode,
  output logic                   trim_unlocked
);

  localparam int TW = dct_pkg::TRIM_W;
  localparam int CW = dct_pkg::CFG_W;

  if (ADDR_W < 16 || ADDR_W > 32) begin : g_chk
    $error("dct_trim_bank: ADDR_W must lie in 16..32");
  end

  typedef struct packed {
    logic [31:0]   key;
    logic [TW-1:0] gain;
    logic [TW-1:0] ofs_atlp;
    logic [TW-1:0] ofs_drlp;
    logic [TW-1:0] ofs_atfs;
    logic [CW-1:0] cfg;
    logic          aw_full;
    logic [15:0]   aw_addr;
    logic          w_full;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [TW-1:0] gain_out;
    logic [TW-1:0] ofs_out;
    logic          atten_out;
    logic          gsel_out;
    logic          fast_out;
    logic          unlocked;
  } dct_state_t;

  dct_state_t s_q;
  dct_state_t s_d;

  logic          fast_lvl;
  logic [TW-1:0] ofs_pick;
  logic          key_ok;
  logic [15:0]   wr_addr;
  logic [15:0]   rd_addr;
  logic [31:0]   wr_word;
  logic [31:0]   rd_word;
  logic          rd_hit;
  logic          wr_hit;

  dct_sync3 #(
    .RST_VAL (1'b0)
  ) u_fast_sync (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .pin_in    (fast_mode_pin),
    .level_out (fast_lvl)
  );

  dct_trim_select #(
    .W (TW)
  ) u_select (
    .atten_on      (s_q.cfg[dct_pkg::CFG_ATTEN_BIT]),
    .fast_mode     (fast_lvl),
    .ofs_atten_lp  (s_q.ofs_atlp),
    .ofs_direct_lp (s_q.ofs_drlp),
    .ofs_atten_fs  (s_q.ofs_atfs),
    .ofs_sel       (ofs_pick)
  );

  // Byte-lane merge of write data onto a register's current value
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  assign key_ok  = (s_q.key == dct_pkg::UNLOCK_KEY);
  assign wr_addr = {s_q.aw_addr[15:2], 2'b00};
  assign rd_addr = {s_axi_araddr[15:2], 2'b00};

  // Read decode; upper bits of every trim word read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (rd_addr)
      dct_pkg::ADDR_KEY: begin
        rd_word = s_q.key;
      end
      dct_pkg::ADDR_GAIN: begin
        rd_word = {20'h0_0000, s_q.gain};
      end
      dct_pkg::ADDR_OFS_ATLP: begin
        rd_word = {20'h0_0000, s_q.ofs_atlp};
      end
      dct_pkg::ADDR_OFS_DRLP: begin
        rd_word = {20'h0_0000, s_q.ofs_drlp};
      end
      dct_pkg::ADDR_OFS_ATFS: begin
        rd_word = {20'h0_0000, s_q.ofs_atfs};
      end
      dct_pkg::ADDR_CFG: begin
        rd_word = {19'h0_0000, s_q.cfg};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_d     = s_q;
    wr_word = 32'h0000_0000;
    wr_hit  = 1'b1;

    // Address and data channels are taken independently, in either order
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.aw_addr = s_axi_awaddr[15:0];
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end

    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end

    // Perform the write once both halves are held and no response waits
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      case (wr_addr)
        dct_pkg::ADDR_KEY: begin
          wr_word = lane_merge(s_q.key, s_q.w_data, s_q.w_strb);
          s_d.key = wr_word;
        end
        dct_pkg::ADDR_GAIN: begin
          wr_word = lane_merge({20'h0_0000, s_q.gain}, s_q.w_data, s_q.w_strb);
          // Locked writes still answer OKAY, they just change nothing
          if (key_ok) begin
            s_d.gain = wr_word[TW-1:0];
          end
        end
        dct_pkg::ADDR_OFS_ATLP: begin
          wr_word = lane_merge({20'h0_0000, s_q.ofs_atlp}, s_q.w_data, s_q.w_strb);
          s_d.ofs_atlp = wr_word[TW-1:0];
        end
        dct_pkg::ADDR_OFS_DRLP: begin
          wr_word = lane_merge({20'h0_0000, s_q.ofs_drlp}, s_q.w_data, s_q.w_strb);
          s_d.ofs_drlp = wr_word[TW-1:0];
        end
        dct_pkg::ADDR_OFS_ATFS: begin
          wr_word = lane_merge({20'h0_0000, s_q.ofs_atfs}, s_q.w_data, s_q.w_strb);
          if (key_ok) begin
            s_d.ofs_atfs = wr_word[TW-1:0];
          end
        end
        dct_pkg::ADDR_CFG: begin
          wr_word = lane_merge({19'h0_0000, s_q.cfg}, s_q.w_data, s_q.w_strb);
          s_d.cfg = wr_word[CW-1:0];
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
      s_d.bresp = wr_hit ? dct_pkg::RESP_OKAY : dct_pkg::RESP_SLVERR;
    end

    // Ready flags follow the next hold state so they come from flops
    s_d.awready = !s_d.aw_full;
    s_d.wready  = !s_d.w_full;

    // Reads: one outstanding, data one cycle after the address is taken
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = rd_word;
      s_d.rresp   = rd_hit ? dct_pkg::RESP_OKAY : dct_pkg::RESP_SLVERR;
    end

    // Converter-side outputs, registered one cycle after their sources
    s_d.gain_out  = s_q.gain;
    s_d.ofs_out   = ofs_pick;
    s_d.atten_out = s_q.cfg[dct_pkg::CFG_ATTEN_BIT];
    s_d.gsel_out  = s_q.cfg[dct_pkg::CFG_GAIN_BIT];
    s_d.fast_out  = fast_lvl;
    s_d.unlocked  = key_ok;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_q          <= '0;
      s_q.key      <= dct_pkg::RST_KEY;
      s_q.gain     <= dct_pkg::RST_GAIN;
      s_q.ofs_atlp <= dct_pkg::RST_OFS;
      s_q.ofs_drlp <= dct_pkg::RST_OFS;
      s_q.ofs_atfs <= dct_pkg::RST_OFS;
      s_q.cfg      <= dct_pkg::RST_CFG;
      s_q.awready  <= 1'b1;
      s_q.wready   <= 1'b1;
      s_q.arready  <= 1'b1;
      s_q.gain_out <= dct_pkg::RST_GAIN;
      s_q.ofs_out  <= dct_pkg::RST_OFS;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready          = s_q.awready;
  assign s_axi_wready           = s_q.wready;
  assign s_axi_bvalid           = s_q.bvalid;
  assign s_axi_bresp            = s_q.bresp;
  assign s_axi_arready          = s_q.arready;
  assign s_axi_rvalid           = s_q.rvalid;
  assign s_axi_rdata            = s_q.rdata;
  assign s_axi_rresp            = s_q.rresp;
  assign gain_trim              = s_q.gain_out;
  assign offset_trim            = s_q.ofs_out;
  assign output_attenuator_on   = s_q.atten_out;
  assign excitation_gain_select = s_q.gsel_out;
  assign fast_mode              = s_q.fast_out;
  assign trim_unlocked          = s_q.unlocked;

endmodule

// file: logic/dct_pkg.sv
/*
  Constants of the converter calibration trim bank: register byte
  addresses, reset values, field widths and the unlock password.
  Assumes a 32-bit AXI4-Lite register bus and a single clock domain.
*/
package dct_pkg;

  localparam int TRIM_W = 12;
  localparam int CFG_W  = 13;

  localparam logic [15:0] ADDR_CFG      = 16'h2010;
  localparam logic [15:0] ADDR_KEY      = 16'h2230;
  localparam logic [15:0] ADDR_GAIN     = 16'h2260;
  localparam logic [15:0] ADDR_OFS_ATLP = 16'h2264;
  localparam logic [15:0] ADDR_OFS_DRLP = 16'h2268;
  localparam logic [15:0] ADDR_OFS_ATFS = 16'h22B8;

  localparam logic [31:0] UNLOCK_KEY    = 32'hDE87_A5AF;
  localparam logic [31:0] RST_KEY       = 32'hDE87_A5A0;
  localparam logic [11:0] RST_GAIN      = 12'h0800;
  localparam logic [11:0] RST_OFS       = 12'h0000;
  localparam logic [12:0] RST_CFG       = 13'h001E;

  localparam int CFG_ATTEN_BIT = 0;
  localparam int CFG_GAIN_BIT  = 12;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: logic/dct_sync3.sv
/*
  Three-stage synchroniser for a level arriving from outside the clock
  domain. The output changes only once stages two and three agree.
  Assumes a synchronous active-high reset.
*/
`timescale 1ns/100ps
module dct_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      level_out
);

  logic [2:0] stage_q;
  logic       level_q;

  // Stage 0 feeds only stage 1, so metastability cannot reach logic
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stage_q <= {3{RST_VAL}};
      level_q <= RST_VAL;
    end else begin
      stage_q <= {stage_q[1:0], pin_in};
      if (stage_q[1] == stage_q[2]) begin
        level_q <= stage_q[2];
      end
    end
  end

  assign level_out = level_q;

endmodule

// file: logic/dct_trim_select.sv
/*
  Picks the offset trim that matches the attenuator state and the
  power mode. Purely combinational; the caller registers the result.
  Assumes all inputs are already in the caller's clock domain.
*/
`timescale 1ns/100ps
module dct_trim_select #(
  parameter int W = 12
) (
  input  wire logic         atten_on,
  input  wire logic         fast_mode,
  input  wire logic [W-1:0] ofs_atten_lp,
  input  wire logic [W-1:0] ofs_direct_lp,
  input  wire logic [W-1:0] ofs_atten_fs,
  output logic      [W-1:0] ofs_sel
);

  if (W < 1) begin : g_chk
    $error("dct_trim_select: W must be at least 1");
  end

  // No direct fast-mode trim exists here, so that corner gets no correction
  always_comb begin
    if (atten_on) begin
      ofs_sel = fast_mode ? ofs_atten_fs : ofs_atten_lp;
    end else begin
      ofs_sel = fast_mode ? '0 : ofs_direct_lp;
    end
  end

endmodule

// file: verif/dct_trim_bank_assertions.sv
/*
  Port checker of the trim bank: key, protection, field and output timing.
  Assumes one clock, synchronous active-high reset, bound to dct_trim_bank.
*/
`timescale 1ns/100ps
module dct_trim_bank_assertions #(
  parameter int ADDR_W = 16
) (
  input wire logic              mclk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic [11:0]       gain_trim,
  input wire logic [11:0]       offset_trim,
  input wire logic              output_attenuator_on,
  input wire logic              excitation_gain_select,
  input wire logic              fast_mode,
  input wire logic              trim_unlocked
);
  logic [15:0] ra_q;
  logic [31:0] wd_q;

  // Address and data vanish from the bus after the handshake, so keep them
  always_ff @(posedge mclk) begin
    if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr[15:0];
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_wr(a);
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr[15:0] == a && s_axi_wstrb == 4'hF;
  endsequence

  AST_RST_VAL: assert property ($fell(sys_rst) |-> !trim_unlocked && gain_trim == 12'h800 && offset_trim == 12'h000)
    else $error("reset values wrong");
  AST_UNLOCK: assert property (s_wr(dct_pkg::ADDR_KEY) ##0 s_axi_wdata == 32'hDE87_A5AF |-> ##3 trim_unlocked)
    else $error("password did not unlock");
  AST_BAD_KEY: assert property (s_wr(dct_pkg::ADDR_KEY) ##0 s_axi_wdata != 32'hDE87_A5AF |-> ##3 !trim_unlocked)
    else $error("wrong key unlocked");
  // Lock state is looked at one edge after the take, when it matches the key the write uses
  AST_LOCKED_GAIN: assert property (s_wr(dct_pkg::ADDR_GAIN) ##1 !trim_unlocked |=> $stable(gain_trim) [*4])
    else $error("locked gain write took effect");
  AST_GAIN_WR: assert property (s_wr(dct_pkg::ADDR_GAIN) ##1 trim_unlocked |-> ##2 gain_trim == wd_q[11:0])
    else $error("gain output wrong after write");
  AST_CFG_OUT: assert property (s_wr(dct_pkg::ADDR_CFG) |-> ##3 output_attenuator_on == wd_q[0] && excitation_gain_select == wd_q[12])
    else $error("config outputs wrong");
  AST_RD_HIGH: assert property (s_axi_rvalid && ra_q inside {16'h2260, 16'h2264, 16'h2268, 16'h22B8} |-> s_axi_rdata[31:12] == 20'h0_0000)
    else $error("trim upper bits not zero");
  AST_OFF_FAST: assert property (!output_attenuator_on && fast_mode && !$past(output_attenuator_on) && $past(fast_mode) |-> offset_trim == 12'h000)
    else $error("offset not zero in fast direct mode");
endmodule

bind dct_trim_bank dct_trim_bank_assertions #(
  .ADDR_W (ADDR_W)
) u_chk (
  .mclk                   (mclk),
  .sys_rst                (sys_rst),
  .s_axi_awaddr           (s_axi_awaddr),
  .s_axi_awvalid          (s_axi_awvalid),
  .s_axi_awready          (s_axi_awready),
  .s_axi_wdata            (s_axi_wdata),
  .s_axi_wstrb            (s_axi_wstrb),
  .s_axi_wvalid           (s_axi_wvalid),
  .s_axi_wready           (s_axi_wready),
  .s_axi_araddr           (s_axi_araddr),
  .s_axi_arvalid          (s_axi_arvalid),
  .s_axi_arready          (s_axi_arready),
  .s_axi_rdata            (s_axi_rdata),
  .s_axi_rvalid           (s_axi_rvalid),
  .gain_trim              (gain_trim),
  .offset_trim            (offset_trim),
  .output_attenuator_on   (output_attenuator_on),
  .excitation_gain_select (excitation_gain_select),
  .fast_mode              (fast_mode),
  .trim_unlocked          (trim_unlocked)
);

// file: verif/test_dct_trim_bank.sv
/*
  Directed bench of the trim bank over AXI4-Lite.
  Assumes the package, the design and the checker are compiled first.
*/
`timescale 1ns/100ps
module test_dct_trim_bank;
  localparam logic [15:0] AK = dct_pkg::ADDR_KEY;
  localparam logic [15:0] AG = dct_pkg::ADDR_GAIN;
  localparam logic [15:0] AL = dct_pkg::ADDR_OFS_ATLP;
  localparam logic [15:0] AD = dct_pkg::ADDR_OFS_DRLP;
  localparam logic [15:0] AF = dct_pkg::ADDR_OFS_ATFS;
  localparam logic [1:0]  OK = dct_pkg::RESP_OKAY;
  localparam logic [11:0] EXP_OFS [4] = '{12'hFFF, 12'h001, 12'h000, 12'h7FF};
  logic        mclk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [15:0] s_axi_awaddr = 16'h0000, s_axi_araddr = 16'h0000;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fast_mode_pin = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [11:0] gain_trim, offset_trim;
  logic        output_attenuator_on, excitation_gain_select, fast_mode, trim_unlocked;
  int          n_fail = 0, samples_checked = 0;

  always #12.5 mclk = ~mclk;

  dct_trim_bank dut_u (
    .mclk                   (mclk),
    .sys_rst                (sys_rst),
    .s_axi_awaddr           (s_axi_awaddr),
    .s_axi_awprot           (s_axi_awprot),
    .s_axi_awvalid          (s_axi_awvalid),
    .s_axi_awready          (s_axi_awready),
    .s_axi_wdata            (s_axi_wdata),
    .s_axi_wstrb            (s_axi_wstrb),
    .s_axi_wvalid           (s_axi_wvalid),
    .s_axi_wready           (s_axi_wready),
    .s_axi_bresp            (s_axi_bresp),
    .s_axi_bvalid           (s_axi_bvalid),
    .s_axi_bready           (s_axi_bready),
    .s_axi_araddr           (s_axi_araddr),
    .s_axi_arprot           (s_axi_arprot),
    .s_axi_arvalid          (s_axi_arvalid),
    .s_axi_arready          (s_axi_arready),
    .s_axi_rdata            (s_axi_rdata),
    .s_axi_rresp            (s_axi_rresp),
    .s_axi_rvalid           (s_axi_rvalid),
    .s_axi_rready           (s_axi_rready),
    .fast_mode_pin          (fast_mode_pin),
    .gain_trim              (gain_trim),
    .offset_trim            (offset_trim),
    .output_attenuator_on   (output_attenuator_on),
    .excitation_gain_select (excitation_gain_select),
    .fast_mode              (fast_mode),
    .trim_unlocked          (trim_unlocked)
  );

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("BAD at %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic hang(input int n);
    if (n >= 40) begin
      n_fail++;
      $display("BAD at %0t: no answer", $time);
      complete_run();
    end
  endtask

  // Each bus task starts on a fresh edge so no signal is driven twice in one step
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er = OK);
    int n = 0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 40);
    s_axi_bready <= 1'b0;
    hang(n);
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [1:0] er);
    int n = 0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 40);
    s_axi_rready <= 1'b0;
    hang(n);
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic do_rst;
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  initial begin
    do_rst();
    chk(32'(trim_unlocked), 32'h0000_0000);
    chk(32'(gain_trim), 32'h0000_0800);
    chk(32'(offset_trim), 32'h0000_0000);
    rd(AK, dct_pkg::RST_KEY, OK);
    rd(AG, 32'h0000_0800, OK);
    rd(AL, 32'h0000_0000, OK);
    rd(AD, 32'h0000_0000, OK);
    rd(AF, 32'h0000_0000, OK);
    rd(16'h2000, 32'h0000_0000, dct_pkg::RESP_SLVERR);
    wr(16'h2000, 32'h0000_1234, dct_pkg::RESP_SLVERR);
    rd(16'h2000, 32'h0000_0000, dct_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(AG, 32'h0000_0FFF);
    wr(AF, 32'h0000_07FF);
    rd(AG, 32'h0000_0800, OK);
    rd(AF, 32'h0000_0000, OK);
    // One bit short of the password must still lock
    wr(AK, 32'hDE87_A5AE);
    wr(AG, 32'h0000_0FFF);
    rd(AG, 32'h0000_0800, OK);
    rd(AK, 32'hDE87_A5AE, OK);
    $display("test locked done");
    wr(AK, dct_pkg::UNLOCK_KEY);
    settle();
    chk(32'(trim_unlocked), 32'h0000_0001);
    wr(AG, 32'hFFFF_FFFF);
    rd(AG, 32'h0000_0FFF, OK);
    wr(AL, 32'h0000_0001);
    wr(AD, 32'hFFFF_FFFF);
    wr(AF, 32'h0000_07FF);
    rd(AL, 32'h0000_0001, OK);
    rd(AD, 32'h0000_0FFF, OK);
    rd(AF, 32'h0000_07FF, OK);
    $display("test unlocked done");
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      fast_mode_pin <= i[1];
      wr(dct_pkg::ADDR_CFG, {19'h0_0000, i[0] ^ i[1], 11'h000, i[0]});
      repeat (8) @(posedge mclk);
      #1;
      chk(32'(offset_trim), 32'(EXP_OFS[i]));
      chk(32'(gain_trim), 32'h0000_0FFF);
      chk(32'(output_attenuator_on), 32'(i[0]));
      chk(32'(excitation_gain_select), 32'(i[0] ^ i[1]));
      chk(32'(fast_mode), 32'(i[1]));
    end
    $display("test select done");
    wr(AK, 32'h0000_0000);
    wr(AF, 32'h0000_0123);
    wr(AG, 32'h0000_0000);
    rd(AF, 32'h0000_07FF, OK);
    rd(AG, 32'h0000_0FFF, OK);
    chk(32'(offset_trim), 32'h0000_07FF);
    $display("test relock done");
    do_rst();
    chk(32'(trim_unlocked), 32'h0000_0000);
    rd(AG, 32'h0000_0800, OK);
    rd(AK, dct_pkg::RST_KEY, OK);
    $display("test second reset done");
    complete_run();
  end
endmodule
